// file: design/bclc_core.sv
// black level correction loop, serial configuration registers, sample strobes and output pipeline
// assumes pins arrive asynchronously and are synchronised here; adc_code and color_index are on sys_clk
// Function
// - automatic mode averages eight black pixel codes while the window is asserted.
// - error equals target level minus averaged black code.
// - two-bit field scales error from full down to one sixteenth.
// - offset-output bit routes applied offset (loop or stored) to the pixel bus instead of DAC.
// - automatic correction runs only while the auto-calibration bit is set.
// - manual mode applies one of four stored offsets, chosen per pixel.
// - sample appears on output pins seven clocks after acquisition.
// - pixel output bus is ten bits wide.
// - reset and video levels taken on falling edges of internal strobes.
// - override pin falling edges replace internal strobe falls, shortening pulses.
// - sixteen eight-bit configuration registers written through the serial port.
// - reset loads every configuration register with its default.
// - default contents give single channel: one gain and one offset.
// - gain register n pairs with offset register n.
// - offset registers are read-only while auto-calibration is enabled.
// - one offset DAC step moves output 0.4 code, range about 54 codes.
// - loop target is the eight-bit black level, reachable up to 54.
// - pipeline latency is seven master clock periods.
`timescale 1ns/100ps

module bclc_core
    import bclc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              ser_clk,
    input  wire logic              ser_data_in,
    input  wire logic              ser_enable_n,
    output logic                   ser_data_out,
    output logic                   ser_data_out_oe,
    input  wire logic              black_clamp_window,
    input  wire logic              reset_sample_override,
    input  wire logic              video_sample_override,
    input  wire logic [1:0]        color_index,
    input  wire logic [ADC_W-1:0]  adc_code,
    output logic                   reset_sample_strobe,
    output logic                   video_sample_strobe,
    output logic                   reset_sample_take,
    output logic                   video_sample_take,
    output logic [REG_DW-1:0]      gain_code,
    output logic [REG_DW-1:0]      offset_code,
    output logic [ADC_W-1:0]       pixel_out,
    output logic                   loop_active
);

    function automatic logic [7:0] reg_default(input logic [3:0] addr);
        case (addr)
            ADDR_BLACK_TARGET: reg_default = RST_BLACK_TARGET;
            ADDR_CTRL0:        reg_default = RST_CTRL0;
            ADDR_CTRL1:        reg_default = RST_CTRL1;
            ADDR_POWER0:       reg_default = RST_POWER0;
            ADDR_POWER1:       reg_default = RST_POWER1;
            default:           reg_default = RST_ZERO;
        endcase
    endfunction

    function automatic logic is_offset_addr(input logic [3:0] addr);
        is_offset_addr = (addr >= ADDR_OFFSET0) && (addr <= ADDR_OFFSET3);
    endfunction

    // pin synchronisers
    logic [PIN_W-1:0]  pin_meta_q;
    logic [PIN_W-1:0]  pin_sync_q;
    logic [PIN_W-1:0]  pin_prev_q;
    logic [PIN_W-1:0]  pin_raw;

    assign pin_raw = {video_sample_override, reset_sample_override, black_clamp_window,
                      ser_enable_n, ser_data_in, ser_clk};

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            // enable idles high; a low reset value would open a false frame after reset
            pin_meta_q <= PIN_W'(1 << PIN_SEN);
            pin_sync_q <= PIN_W'(1 << PIN_SEN);
            pin_prev_q <= PIN_W'(1 << PIN_SEN);
        end
        else
        begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sen_fall;
    logic sen_rise;
    logic sen_active;
    logic rovr_fall;
    logic vovr_fall;
    logic blk_level;

    assign sclk_rise  = pin_sync_q[PIN_SCLK] & ~pin_prev_q[PIN_SCLK];
    assign sclk_fall  = ~pin_sync_q[PIN_SCLK] & pin_prev_q[PIN_SCLK];
    assign sen_fall   = ~pin_sync_q[PIN_SEN] & pin_prev_q[PIN_SEN];
    assign sen_rise   = pin_sync_q[PIN_SEN] & ~pin_prev_q[PIN_SEN];
    assign sen_active = ~pin_sync_q[PIN_SEN];
    assign rovr_fall  = ~pin_sync_q[PIN_ROVR] & pin_prev_q[PIN_ROVR];
    assign vovr_fall  = ~pin_sync_q[PIN_VOVR] & pin_prev_q[PIN_VOVR];
    assign blk_level  = pin_sync_q[PIN_BLK];

    // configuration registers
    logic [REG_DW-1:0]  cfg_q [REG_COUNT];
    logic [3:0]         bit_cnt_q;
    logic [12:0]        cmd_shift_q;
    logic [7:0]         rd_shift_q;
    logic               rd_drive_q;
    logic signed [7:0]  integ_q;

    logic               auto_en;
    logic               ofs_out_en;
    logic               single_ch;
    logic [1:0]         scale_sel;
    logic               rovr_en;
    logic               vovr_en;

    assign auto_en    = cfg_q[ADDR_CTRL0][CTRL0_AUTO_BIT];
    assign ofs_out_en = cfg_q[ADDR_CTRL0][CTRL0_OFS_OUT_BIT];
    assign single_ch  = cfg_q[ADDR_CTRL0][CTRL0_SINGLE_BIT];
    assign scale_sel  = cfg_q[ADDR_CTRL0][CTRL0_SCALE_LSB+1:CTRL0_SCALE_LSB];
    assign rovr_en    = cfg_q[ADDR_CTRL1][CTRL1_RST_OVR_BIT];
    assign vovr_en    = cfg_q[ADDR_CTRL1][CTRL1_VID_OVR_BIT];

    logic        cmd_read;
    logic [3:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic [7:0]  rd_value;

    assign cmd_read = cmd_shift_q[12];
    assign cmd_addr = cmd_shift_q[11:8];
    assign cmd_data = cmd_shift_q[7:0];

    // offsets under the loop read back the live integrator
    always_comb
    begin
        rd_value = cfg_q[cmd_shift_q[3:0]];
        if (auto_en && is_offset_addr(cmd_shift_q[3:0]))
            rd_value = integ_q;
    end

    // bit counter and command shifter; bits past the thirteenth are ignored
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bit_cnt_q   <= 4'd0;
            cmd_shift_q <= 13'h0000;
        end
        else if (sen_fall)
        begin
            bit_cnt_q   <= 4'd0;
            cmd_shift_q <= 13'h0000;
        end
        else if (sen_active && sclk_rise && bit_cnt_q < CMD_BITS)
        begin
            bit_cnt_q   <= bit_cnt_q + 4'd1;
            cmd_shift_q <= {cmd_shift_q[11:0], pin_sync_q[PIN_SDI]};
        end
    end

    // read data leaves msb first on falling serial clock after the header
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rd_shift_q <= 8'h00;
            rd_drive_q <= 1'b0;
        end
        else if (!sen_active)
        begin
            rd_drive_q <= 1'b0;
        end
        else if (bit_cnt_q == CMD_HDR_BITS && sclk_fall && cmd_shift_q[4])
        begin
            rd_shift_q <= rd_value;
            rd_drive_q <= 1'b1;
        end
        else if (rd_drive_q && sclk_fall)
        begin
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
        end
    end

    assign ser_data_out    = rd_drive_q & rd_shift_q[7];
    assign ser_data_out_oe = rd_drive_q;

    logic wr_commit;

    // a short command is dropped whole
    assign wr_commit = sen_rise && (bit_cnt_q == CMD_BITS) && !cmd_read;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                cfg_q[i] <= reg_default(i[3:0]);
        end
        else if (wr_commit && !(auto_en && is_offset_addr(cmd_addr[3:0])))
        begin
            cfg_q[cmd_shift_q[11:8] & 4'hF] <= cmd_data;
        end
    end

    // internal strobes: reset strobe high while phase_q is 1, video strobe while phase_q is 0
    logic  phase_q;
    logic  rst_strb_q;
    logic  vid_strb_q;
    logic  rst_take_q;
    logic  vid_take_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            phase_q <= 1'b0;
        else
            phase_q <= ~phase_q;
    end

    // an enabled override fall ends the pulse early and takes the sample in place of the internal fall
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rst_strb_q <= 1'b0;
            vid_strb_q <= 1'b0;
            rst_take_q <= 1'b0;
            vid_take_q <= 1'b0;
        end
        else
        begin
            rst_strb_q <= !phase_q && !(rovr_en && rovr_fall);
            vid_strb_q <= phase_q && !(vovr_en && vovr_fall);
            rst_take_q <= rovr_en ? (rovr_fall && rst_strb_q) : (rst_strb_q && phase_q);
            vid_take_q <= vovr_en ? (vovr_fall && vid_strb_q) : (vid_strb_q && !phase_q);
        end
    end

    assign reset_sample_strobe = rst_strb_q;
    assign video_sample_strobe = vid_strb_q;
    assign reset_sample_take   = rst_take_q;
    assign video_sample_take   = vid_take_q;

    // output pipeline: six stages here and the output register give seven clocks
    logic [ADC_W-1:0] acq_q;
    logic [ADC_W-1:0] pipe_q [PIPE_LATENCY-1];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            acq_q     <= '0;
            pipe_q[0] <= '0;
        end
        else
        begin
            if (vid_take_q)
                acq_q <= adc_code;
            pipe_q[0] <= vid_take_q ? adc_code : acq_q;
        end
    end

    genvar g;
    generate
        for (g = 1; g < PIPE_LATENCY - 1; g++)
        begin : g_pipe
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                    pipe_q[g] <= '0;
                else
                    pipe_q[g] <= pipe_q[g-1];
            end
        end
    endgenerate

    // black level loop
    bclc_loop_t         loop_q;
    logic [4:0]         hi_cnt_q;
    logic [2:0]         avg_cnt_q;
    logic [12:0]        sum_q;
    logic               armed;

    assign armed = auto_en && blk_level;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            hi_cnt_q <= 5'd0;
        else if (!blk_level)
            hi_cnt_q <= 5'd0;
        else if (hi_cnt_q < BLK_MIN_CYCLES)
            hi_cnt_q <= hi_cnt_q + 5'd1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            loop_q    <= LOOP_IDLE;
            avg_cnt_q <= 3'd0;
            sum_q     <= 13'h0000;
        end
        else
        begin
            case (loop_q)
                LOOP_IDLE:
                begin
                    avg_cnt_q <= 3'd0;
                    sum_q     <= 13'h0000;
                    if (armed)
                        loop_q <= LOOP_ACC;
                end
                LOOP_ACC:
                begin
                    if (!armed)
                        loop_q <= LOOP_IDLE;
                    else if (vid_take_q)
                    begin
                        sum_q     <= sum_q + {3'b000, adc_code};
                        avg_cnt_q <= avg_cnt_q + 3'd1;
                        if (avg_cnt_q == AVG_LAST)
                            loop_q <= LOOP_UPD;
                    end
                end
                LOOP_UPD:
                begin
                    sum_q     <= 13'h0000;
                    avg_cnt_q <= 3'd0;
                    loop_q    <= armed ? LOOP_ACC : LOOP_IDLE;
                end
                default:
                    loop_q <= LOOP_IDLE;
            endcase
        end
    end

    logic [7:0]          target;
    logic [ADC_W-1:0]    avg_code;
    logic signed [10:0]  err;
    logic signed [10:0]  err_scaled;
    logic signed [11:0]  integ_next;

    // the offset DAC moves 0.4 code a step, so targets above 54 cannot be reached
    assign target     = (cfg_q[ADDR_BLACK_TARGET] > TARGET_MAX) ? TARGET_MAX : cfg_q[ADDR_BLACK_TARGET];
    assign avg_code   = sum_q[ADC_W+AVG_SHIFT-1:AVG_SHIFT];
    assign err        = $signed({3'b000, target}) - $signed({1'b0, avg_code});
    // top setting jumps to one sixteenth so two bits span full down to /16
    assign err_scaled = err >>> ((scale_sel == 2'd3) ? 3'd4 : {1'b0, scale_sel});
    assign integ_next = 12'(integ_q) + 12'(err_scaled);

    // an update only counts when the window has been held long enough
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            integ_q <= 8'sh00;
        else if (loop_q == LOOP_UPD && hi_cnt_q == BLK_MIN_CYCLES && auto_en)
        begin
            if (integ_next > 12'(OFS_MAX))
                integ_q <= OFS_MAX;
            else if (integ_next < 12'(OFS_MIN))
                integ_q <= OFS_MIN;
            else
                integ_q <= integ_next[7:0];
        end
    end

    assign loop_active = (loop_q != LOOP_IDLE);

    // gain and offset selection, register n paired with offset n
    logic [1:0]  chan;
    logic [7:0]  ofs_applied;

    assign chan        = single_ch ? 2'd0 : color_index;
    assign ofs_applied = auto_en ? integ_q : cfg_q[ADDR_OFFSET0 + {2'b00, chan}];

    logic [REG_DW-1:0] gain_q;
    logic [REG_DW-1:0] ofs_q;
    logic [ADC_W-1:0]  pix_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            gain_q <= RST_ZERO;
            ofs_q  <= RST_ZERO;
        end
        else
        begin
            gain_q <= cfg_q[ADDR_GAIN0 + {2'b00, chan}];
            ofs_q  <= ofs_out_en ? RST_ZERO : ofs_applied;
        end
    end

    // offset takes the bus, sign-extended, while routed out
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pix_q <= '0;
        else if (ofs_out_en)
            pix_q <= {{(ADC_W-8){ofs_applied[7]}}, ofs_applied};
        else
            pix_q <= pipe_q[PIPE_LATENCY-2];
    end

    assign gain_code   = gain_q;
    assign offset_code = ofs_q;
    assign pixel_out   = pix_q;

endmodule

// file: design/bclc_pkg.sv
// constants, field positions and types for the black level correction loop
// assumes one master clock domain; every figure here is named once and shared
package bclc_pkg;

    // register file
    localparam int unsigned REG_COUNT = 16;
    localparam int unsigned REG_AW    = 4;
    localparam int unsigned REG_DW    = 8;

    localparam logic [3:0] ADDR_GAIN0        = 4'h0;
    localparam logic [3:0] ADDR_OFFSET0      = 4'h4;
    localparam logic [3:0] ADDR_OFFSET3      = 4'h7;
    localparam logic [3:0] ADDR_BLACK_TARGET = 4'hB;
    localparam logic [3:0] ADDR_CTRL0        = 4'hC;
    localparam logic [3:0] ADDR_CTRL1        = 4'hD;
    localparam logic [3:0] ADDR_POWER0       = 4'hE;
    localparam logic [3:0] ADDR_POWER1       = 4'hF;

    // reset values
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_BLACK_TARGET = 8'h20;
    localparam logic [7:0] RST_CTRL0        = 8'h4E;
    localparam logic [7:0] RST_CTRL1        = 8'h00;
    localparam logic [7:0] RST_POWER0       = 8'hAA;
    localparam logic [7:0] RST_POWER1       = 8'h5A;

    // control register 0 fields
    localparam int unsigned CTRL0_OFS_OUT_BIT = 0;
    localparam int unsigned CTRL0_SCALE_LSB   = 4;
    localparam int unsigned CTRL0_SINGLE_BIT  = 6;
    localparam int unsigned CTRL0_AUTO_BIT    = 7;
    // control register 1 fields
    localparam int unsigned CTRL1_RST_OVR_BIT = 0;
    localparam int unsigned CTRL1_VID_OVR_BIT = 1;

    // serial command: read flag, 4 address bits, 8 data bits, msb first
    localparam logic [3:0] CMD_BITS      = 4'd13;
    localparam logic [3:0] CMD_HDR_BITS  = 4'd5;

    // loop and datapath
    localparam logic [4:0] BLK_MIN_CYCLES  = 5'd20;
    localparam logic [2:0] AVG_LAST        = 3'd7;
    localparam int unsigned AVG_SHIFT      = 3;
    localparam int unsigned PIPE_LATENCY   = 7;
    localparam int unsigned ADC_W          = 10;
    localparam logic [7:0] TARGET_MAX      = 8'd54;
    localparam int unsigned DAC_STEP_TENTHS = 4;
    localparam logic signed [7:0] OFS_MAX  = 8'sh7F;
    localparam logic signed [7:0] OFS_MIN  = -8'sh80;

    // synchronised pin vector positions
    localparam int unsigned PIN_SCLK = 0;
    localparam int unsigned PIN_SDI  = 1;
    localparam int unsigned PIN_SEN  = 2;
    localparam int unsigned PIN_BLK  = 3;
    localparam int unsigned PIN_ROVR = 4;
    localparam int unsigned PIN_VOVR = 5;
    localparam int unsigned PIN_W    = 6;

    typedef enum logic [1:0] {
        LOOP_IDLE = 2'b00,
        LOOP_ACC  = 2'b01,
        LOOP_UPD  = 2'b10
    } bclc_loop_t;

endpackage

// file: tb/bclc_core_asserts.sv
// concurrent checks on the ports of bclc_core
// assumes one clock, sys_clk, and the synchronous active-low rst_n
`timescale 1ns/100ps

module bclc_core_asserts
    import bclc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              ser_enable_n,
    input  wire logic              ser_data_out_oe,
    input  wire logic              black_clamp_window,
    input  wire logic              reset_sample_strobe,
    input  wire logic              video_sample_strobe,
    input  wire logic              reset_sample_take,
    input  wire logic              video_sample_take,
    input  wire logic [REG_DW-1:0] offset_code,
    input  wire logic [ADC_W-1:0]  pixel_out,
    input  wire logic              loop_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_strobe_exclusive: assert property (!(reset_sample_strobe && video_sample_strobe))
        else $error("both sample strobes high");
    a_vtake_single: assert property (video_sample_take |=> !video_sample_take)
        else $error("video take longer than one cycle");
    a_rtake_single: assert property (reset_sample_take |=> !reset_sample_take)
        else $error("reset take longer than one cycle");
    a_takes_apart: assert property (!(reset_sample_take && video_sample_take))
        else $error("reset and video taken together");
    a_rtake_fall: assert property ($fell(reset_sample_strobe) |-> ##[0:1] reset_sample_take)
        else $error("reset strobe fell without a take");
    a_vtake_fall: assert property ($fell(video_sample_strobe) |-> ##[0:1] video_sample_take)
        else $error("video strobe fell without a take");
    // must stay live during reset, so the default disable is overridden
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> pixel_out == 10'h000 && offset_code == 8'h00 && !loop_active)
        else $error("outputs not cleared by reset");
    a_oe_in_frame: assert property ($rose(ser_data_out_oe) |-> !ser_enable_n)
        else $error("read driver on outside a frame");
    a_oe_release: assert property (ser_enable_n [*6] |-> !ser_data_out_oe)
        else $error("read driver left on after frame");
    a_loop_window: assert property ($rose(loop_active) |->
        $past(black_clamp_window, 2) || $past(black_clamp_window, 3))
        else $error("loop started without clamp window");
    a_loop_idle: assert property (!black_clamp_window [*6] |-> !loop_active)
        else $error("loop active with window low");

    c_loop: cover property ($rose(loop_active));
    c_read: cover property ($rose(ser_data_out_oe));
    c_rtake: cover property ($fell(reset_sample_strobe) ##1 reset_sample_take);
endmodule

bind bclc_core bclc_core_asserts u_chk (.sys_clk, .rst_n, .ser_enable_n, .ser_data_out_oe,
    .black_clamp_window, .reset_sample_strobe, .video_sample_strobe, .reset_sample_take,
    .video_sample_take, .offset_code, .pixel_out, .loop_active);

// file: tb/bclc_partner.sv
// host serial controller and clamp-window source facing bclc_core
// assumes sys_clk runs free; every pin changes on its falling edge
`timescale 1ns/100ps

module bclc_partner (
    input  wire logic sys_clk,
    output logic      ser_clk,
    output logic      ser_data_in,
    output logic      ser_enable_n,
    input  wire logic ser_data_out,
    input  wire logic ser_data_out_oe,
    output logic      black_clamp_window
);
    initial
    begin
        ser_clk = 1'b0;
        ser_data_in = 1'b1;
        ser_enable_n = 1'b1;
        black_clamp_window = 1'b0;
    end

    // n bits of cmd sent msb first; 4 clocks a phase clears the 3-clock synchroniser
    task automatic xfer(input int n, input logic [12:0] cmd, output logic [7:0] rd);
        rd = 8'hXX;
        @(negedge sys_clk) ser_enable_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            ser_data_in = cmd[12-i];
            repeat (4) @(negedge sys_clk);
            ser_clk = 1'b1;
            if (i > 4)
                rd[12-i] = ser_data_out_oe ? ser_data_out : 1'bx;
            repeat (4) @(negedge sys_clk);
            ser_clk = 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        ser_enable_n = 1'b1;
        // released data line shows the inverse, never a stale copy
        ser_data_in = ~ser_data_in;
        repeat (6) @(negedge sys_clk);
    endtask

    task automatic clamp(input int n);
        @(negedge sys_clk) black_clamp_window = 1'b1;
        repeat (n) @(negedge sys_clk);
        black_clamp_window = 1'b0;
    endtask
endmodule

// file: tb/test_black_level_correction_loop.sv
// self-checking bench for bclc_core driven through its serial register port
// assumes bclc_partner as the host and clamp source; pixel inputs driven here
`timescale 1ns/100ps

module test_black_level_correction_loop;
    import bclc_pkg::*;

    logic       sys_clk;
    logic       rst_n;
    logic       ser_clk;
    logic       ser_data_in;
    logic       ser_enable_n;
    logic       ser_data_out;
    logic       ser_data_out_oe;
    logic       black_clamp_window;
    logic       reset_sample_override = 1'b1;
    logic       video_sample_override = 1'b1;
    logic [1:0] color_index;
    logic [9:0] adc_code = 10'h000;
    logic       rs_strobe;
    logic       vs_strobe;
    logic       rs_take;
    logic       video_sample_take;
    logic [7:0] gain_code;
    logic [7:0] offset_code;
    logic [9:0] pixel_out;
    logic       loop_active;
    logic       adc_hold;
    logic       ovr_run;
    logic [7:0] r;
    logic [7:0] v;
    int         miscompares;
    int         total_checks;
    int         n;

    bclc_core u_dut (.sys_clk, .rst_n, .ser_clk, .ser_data_in, .ser_enable_n, .ser_data_out,
        .ser_data_out_oe, .black_clamp_window, .reset_sample_override, .video_sample_override,
        .color_index, .adc_code, .reset_sample_strobe(rs_strobe), .video_sample_strobe(vs_strobe),
        .reset_sample_take(rs_take), .video_sample_take, .gain_code, .offset_code, .pixel_out,
        .loop_active);
    bclc_partner u_p (.sys_clk, .ser_clk, .ser_data_in, .ser_enable_n, .ser_data_out,
        .ser_data_out_oe, .black_clamp_window);

    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    // while adc_hold is low a fresh code every cycle makes a wrong pipeline depth visible
    always @(negedge sys_clk)
    begin
        adc_code <= adc_hold ? 10'h017 : adc_code + 10'h001;
        if (ovr_run)
        begin
            reset_sample_override <= ~reset_sample_override;
            video_sample_override <= reset_sample_override;
        end
    end

    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_p.xfer(13, {1'b0, a, d}, r);
    endtask

    task automatic rd(input logic [3:0] a);
        u_p.xfer(13, {1'b1, a, 8'h00}, r);
    endtask

    task automatic lat();
        logic [9:0] x;
        do @(negedge sys_clk); while (video_sample_take !== 1'b1);
        x = adc_code + 10'h001;
        repeat (6) @(negedge sys_clk);
        chk("pixel early", pixel_out !== x, 10'h001);
        @(negedge sys_clk);
        chk("pixel", pixel_out, x);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        miscompares++;
        finish_test();
    end

    initial
    begin
        logic [3:0] da [7];
        logic [7:0] dv [7];
        da = '{ADDR_GAIN0, ADDR_OFFSET0, ADDR_BLACK_TARGET, ADDR_CTRL0, ADDR_CTRL1, ADDR_POWER0, ADDR_POWER1};
        dv = '{RST_ZERO, RST_ZERO, RST_BLACK_TARGET, RST_CTRL0, RST_CTRL1, RST_POWER0, RST_POWER1};
        rst_n = 1'b0;
        color_index = 2'h3;
        adc_hold = 1'b0;
        ovr_run = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd(da[i]);
            chk("default", r, dv[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(4'(i), 8'(8'h30 + i));
            wr(4'(i + 4), 8'(8'hC0 + i));
        end
        for (int i = 0; i < 8; i++)
        begin
            rd(4'(i));
            chk("readback", r, 10'((i < 4) ? 8'h30 + i : 8'hBC + i));
        end
        chk("single gain", gain_code, 8'h30);
        chk("single offset", offset_code, 8'hC0);
        wr(ADDR_CTRL0, 8'h0E);
        for (int i = 0; i < 4; i++)
        begin
            @(negedge sys_clk) color_index = 2'(i);
            repeat (4) @(negedge sys_clk);
            chk("pair gain", gain_code, 10'(8'h30 + i));
            chk("pair offset", offset_code, 10'(8'hC0 + i));
        end
        u_p.xfer(12, {1'b0, ADDR_GAIN0, 8'h5A}, r);
        rd(ADDR_GAIN0);
        chk("short command", r, 8'h30);
        wr(ADDR_CTRL0, 8'h4E);
        repeat (3) lat();
        wr(ADDR_CTRL0, 8'h4F);
        repeat (6) @(negedge sys_clk);
        chk("offset out", pixel_out, 10'h3C0);
        chk("dac idle", offset_code, 8'h00);
        // overrides fall in step with the internal pulses and run before the enable and after the disable,
        // so no strobe fall while enabled is left without an override fall
        do @(negedge sys_clk); while (rs_strobe !== 1'b0);
        ovr_run <= 1'b1;
        wr(ADDR_CTRL1, 8'h03);
        n = 0;
        repeat (40) @(negedge sys_clk) n += (rs_take === 1'b1);
        chk("override takes", 10'(n), 10'h014);
        wr(ADDR_CTRL1, 8'h00);
        ovr_run <= 1'b0;
        // target above the reachable ceiling, written before the window
        wr(ADDR_BLACK_TARGET, 8'h3C);
        wr(ADDR_CTRL0, 8'hDE);
        wr(ADDR_OFFSET0, 8'h33);
        rd(ADDR_OFFSET0);
        chk("offset locked", r, 8'h00);
        adc_hold = 1'b1;
        u_p.clamp(60);
        repeat (10) @(negedge sys_clk);
        rd(ADDR_OFFSET0);
        v = r;
        // (54 - 23) >>> 1 = 15 a group; other scales or an unclamped target miss multiples of 15
        chk("integrator", v % 15 == 0 && v >= 8'h0F && v <= 8'h2D, 10'h001);
        chk("applied", offset_code, v);
        repeat (40) @(negedge sys_clk);
        // one full group completes, but the window is shorter than the minimum
        u_p.clamp(18);
        rd(ADDR_OFFSET0);
        chk("held", r, v);
        finish_test();
    end
endmodule
